/* shared/dma_status_pkg.sv */
/*
  Shared constants and carriers for the DMA channel status view.
  Assumes one 100 MHz clock and a simple strobed register port.
*/
package dma_status_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 12;
  localparam int NUM_LVL = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int ID_W = 5;

  // ---------------------------------------------------------------
  // register map and field positions
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_IRQ_SUMMARY = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_BUSY_FLAGS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PEND_FLAGS = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 8'h30;
  localparam int POS_COUNT = 16;
  localparam int POS_ACTIVE_BUSY_FLAG = 15;
  localparam int POS_ID = 8;
  localparam int POS_LVL = 0;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_CH-1:0] start;     // channel begins a transfer
    logic [NUM_CH-1:0] actStart;  // trigger action execution starts
    logic [NUM_CH-1:0] actDone;   // trigger action finished
    logic [NUM_CH-1:0] busErr;
    logic [NUM_CH-1:0] disable_;
    logic [NUM_CH-1:0] request;   // transfer waiting on channel
  } chan_evt_t;

  typedef struct packed {
    logic grant;                  // arbiter grants a new channel
    logic [ID_W-1:0] grantId;
    logic fetchCount;             // count read from write-back memory
    logic [CNT_W-1:0] fetchedCount;
    logic countUpdate;            // engine updates the running count
    logic [CNT_W-1:0] newCount;
    logic wbDone;                 // count written back
  } active_evt_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
    logic [CNT_W-1:0] count;
  } wb_req_t;

  typedef enum logic [1:0] {ACT_IDLE, ACT_RUN, ACT_WB} act_state_t;
endpackage

/* hw/dma_channel_status_view.sv */
/*
  Read-only status view of a twelve-channel DMA controller: interrupt
  summary, busy and pending flags, active channel snapshot.
  Assumes event inputs are single-cycle pulses from logic on sys_clk.
*/
// Operation
// - summary bit set while channel has any enabled interrupt pending
// - summary bit clears when interrupts disabled or sources cleared
// - busy bit sets when channel starts a transfer
// - busy bit clears on action done, bus error or disable
// - pending bit sets while a transfer waits on channel
// - pending bit clears on action start, bus error or disable
// - unused upper bits of the three flag registers read zero
// - snapshot shows 16-bit remaining count, written back on a grant while a channel is active
// - active busy sets on count fetch, clears after write-back
// - active index takes granted channel number on every grant
// - per-level flag set while a level request executes or pends
module dma_channel_status_view
  import dma_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire reg_req_t regReq,
  output logic [DATA_W-1:0] rdata,
  input wire logic [NUM_CH-1:0] chIrqFlags,
  input wire logic [NUM_CH-1:0] chIrqEnable,
  input wire chan_evt_t chEvt,
  input wire active_evt_t actEvt,
  input wire logic [NUM_LVL-1:0] lvlActive,
  output wb_req_t wbReq
);

  // ---------------------------------------------------------------
  // channel flags
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] channel_irq_pending_bit_r;
  logic [NUM_CH-1:0] channel_busy_bit_r;
  logic [NUM_CH-1:0] channel_waiting_bit_r;

  // level summary, recomputed every cycle from the sources
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_irq_pending_bit_r <= '0;
    end else begin
      channel_irq_pending_bit_r <= chIrqFlags & chIrqEnable;
    end
  end

  // start wins over a clear in the same cycle so no transfer is lost
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_busy_bit_r <= '0;
    end else begin
      channel_busy_bit_r <= (channel_busy_bit_r
        & ~(chEvt.actDone | chEvt.busErr | chEvt.disable_))
        | chEvt.start;
    end
  end

  // a new request beats a clear only while the channel stays enabled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel_waiting_bit_r <= '0;
    end else begin
      channel_waiting_bit_r <= ((channel_waiting_bit_r
        & ~(chEvt.actStart | chEvt.busErr))
        | chEvt.request)
        & ~chEvt.disable_;
    end
  end

  // ---------------------------------------------------------------
  // active channel snapshot
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] remaining_beat_count_r;
  logic active_busy_flag_r;
  logic [ID_W-1:0] activeId_r;
  logic [NUM_LVL-1:0] level_executing_flag_r;
  act_state_t actState_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      remaining_beat_count_r <= '0;
    end else if (actEvt.fetchCount) begin
      remaining_beat_count_r <= actEvt.fetchedCount;
    end else if (actEvt.countUpdate) begin
      remaining_beat_count_r <= actEvt.newCount;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      activeId_r <= '0;
    end else if (actEvt.grant) begin
      activeId_r <= actEvt.grantId;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      level_executing_flag_r <= '0;
    end else begin
      level_executing_flag_r <= lvlActive;
    end
  end

  // write-back request goes out on a grant while a channel is active
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      actState_r <= ACT_IDLE;
      active_busy_flag_r <= 1'b0;
      wbReq <= '0;
    end else begin
      wbReq.valid <= 1'b0;
      case (actState_r)
        ACT_IDLE: begin
          if (actEvt.fetchCount) begin
            active_busy_flag_r <= 1'b1;
            actState_r <= ACT_RUN;
          end
        end
        ACT_RUN: begin
          if (actEvt.grant) begin
            wbReq.valid <= 1'b1;
            wbReq.id <= activeId_r;
            wbReq.count <= remaining_beat_count_r;
            actState_r <= ACT_WB;
          end
        end
        ACT_WB: begin
          if (actEvt.wbDone) begin
            active_busy_flag_r <= 1'b0;
            actState_r <= ACT_IDLE;
          end
        end
        default: begin
          actState_r <= ACT_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register read port; writes are ignored
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rdNxt;

  always_comb begin
    rdNxt = RST_WORD;
    case (regReq.addr)
      OFS_IRQ_SUMMARY: rdNxt[NUM_CH-1:0] = channel_irq_pending_bit_r;
      OFS_BUSY_FLAGS: rdNxt[NUM_CH-1:0] = channel_busy_bit_r;
      OFS_PEND_FLAGS: rdNxt[NUM_CH-1:0] = channel_waiting_bit_r;
      OFS_ACTIVE: begin
        rdNxt[POS_COUNT +: CNT_W] = remaining_beat_count_r;
        rdNxt[POS_ACTIVE_BUSY_FLAG] = active_busy_flag_r;
        rdNxt[POS_ID +: ID_W] = activeId_r;
        rdNxt[POS_LVL +: NUM_LVL] = level_executing_flag_r;
      end
      default: rdNxt = RST_WORD;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata <= RST_WORD;
    end else if (regReq.rd) begin
      rdata <= rdNxt;
    end else begin
      rdata <= RST_WORD;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_irqSummary;
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> channel_irq_pending_bit_r == $past(chIrqFlags & chIrqEnable);
  endproperty
  a_irqSummary: assert property (p_irqSummary)
    else $error("summary bit does not follow pending sources");

  property p_irqClear;
    @(posedge sys_clk) disable iff (srst)
    (chIrqEnable == '0) |=> channel_irq_pending_bit_r == '0;
  endproperty
  a_irqClear: assert property (p_irqClear)
    else $error("summary bit stays set with interrupts disabled");

  property p_busySet;
    @(posedge sys_clk) disable iff (srst)
    chEvt.start[0] |=> channel_busy_bit_r[0];
  endproperty
  a_busySet: assert property (p_busySet)
    else $error("busy bit not set on transfer start");

  property p_busyClr;
    @(posedge sys_clk) disable iff (srst)
    (chEvt.busErr[0] && !chEvt.start[0]) |=> !channel_busy_bit_r[0];
  endproperty
  a_busyClr: assert property (p_busyClr)
    else $error("busy bit not cleared on bus error");

  property p_pendSet;
    @(posedge sys_clk) disable iff (srst)
    (chEvt.request[0] && !chEvt.disable_[0]) |=> channel_waiting_bit_r[0];
  endproperty
  a_pendSet: assert property (p_pendSet)
    else $error("pending bit not set on waiting transfer");

  property p_pendClr;
    @(posedge sys_clk) disable iff (srst)
    chEvt.disable_[0] |=> !channel_waiting_bit_r[0];
  endproperty
  a_pendClr: assert property (p_pendClr)
    else $error("pending bit survives channel disable");

  property p_upperZero;
    @(posedge sys_clk) disable iff (srst)
    (regReq.rd && regReq.addr != OFS_ACTIVE)
      |=> rdata[DATA_W-1:NUM_CH] == '0;
  endproperty
  a_upperZero: assert property (p_upperZero)
    else $error("unused upper bits read nonzero");

  sequence s_granted;
    actState_r == ACT_RUN && actEvt.grant;
  endsequence
  property p_writeBack;
    @(posedge sys_clk) disable iff (srst)
    s_granted |=> wbReq.valid && wbReq.count == $past(remaining_beat_count_r);
  endproperty
  a_writeBack: assert property (p_writeBack)
    else $error("count not written back on new grant");

  sequence s_fetch;
    actState_r == ACT_IDLE && actEvt.fetchCount;
  endsequence
  property p_active_busy_flag;
    @(posedge sys_clk) disable iff (srst)
    s_fetch |=> active_busy_flag_r;
  endproperty
  a_active_busy_flag: assert property (p_active_busy_flag)
    else $error("active busy not set on count fetch");

  property p_activeId;
    @(posedge sys_clk) disable iff (srst)
    actEvt.grant |=> activeId_r == $past(actEvt.grantId);
  endproperty
  a_activeId: assert property (p_activeId)
    else $error("active index not updated on grant");

  property p_level;
    @(posedge sys_clk) disable iff (srst)
    (regReq.rd && regReq.addr == OFS_ACTIVE)
      |=> rdata[POS_LVL +: NUM_LVL] == $past(level_executing_flag_r);
  endproperty
  a_level: assert property (p_level)
    else $error("level flags misreported");

  property p_levelTrack;
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> level_executing_flag_r == $past(lvlActive);
  endproperty
  a_levelTrack: assert property (p_levelTrack)
    else $error("level flags do not follow executing levels");

  property p_busyAll;
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> (channel_busy_bit_r & $past(chEvt.start))
      == $past(chEvt.start);
  endproperty
  a_busyAll: assert property (p_busyAll)
    else $error("busy bit not set on some channel start");

  // a clear with no start in the same cycle must drop the busy bit of every cleared channel
  property p_busyClrAll;
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> (channel_busy_bit_r & $past((chEvt.actDone | chEvt.busErr
      | chEvt.disable_) & ~chEvt.start)) == '0;
  endproperty
  a_busyClrAll: assert property (p_busyClrAll)
    else $error("busy bit survives a clear");

  property p_pendSetAll;
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> (channel_waiting_bit_r & $past(chEvt.request & ~chEvt.disable_))
      == $past(chEvt.request & ~chEvt.disable_);
  endproperty
  a_pendSetAll: assert property (p_pendSetAll)
    else $error("pending bit not set on some channel");

  property p_pendClrAll;
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> (channel_waiting_bit_r & $past(((chEvt.actStart | chEvt.busErr)
      & ~chEvt.request) | chEvt.disable_)) == '0;
  endproperty
  a_pendClrAll: assert property (p_pendClrAll)
    else $error("pending bit survives a clear");

  sequence s_wbDone;
    actState_r == ACT_WB && actEvt.wbDone;
  endsequence
  property p_abusyClr;
    @(posedge sys_clk) disable iff (srst)
    s_wbDone |=> !active_busy_flag_r;
  endproperty
  a_abusyClr: assert property (p_abusyClr)
    else $error("active busy not cleared after write-back");

  property p_wbId;
    @(posedge sys_clk) disable iff (srst)
    s_granted |=> wbReq.id == $past(activeId_r);
  endproperty
  a_wbId: assert property (p_wbId)
    else $error("write-back carries the wrong channel index");

  property p_noWb;
    @(posedge sys_clk) disable iff (srst)
    !(actState_r == ACT_RUN && actEvt.grant) |=> !wbReq.valid;
  endproperty
  a_noWb: assert property (p_noWb)
    else $error("write-back issued without a grant on an active channel");

endmodule

/* verification/tb_top.sv */
/*
  Self-checking bench for the DMA channel status view: register reads,
  channel events and active-channel snapshot.
  Assumes the package and the design module compile before this file.
*/
module tb_top
  import dma_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  localparam int F_REQ = 0;
  localparam int F_DIS = 1;
  localparam int F_ERR = 2;
  localparam int F_DONE = 3;
  localparam int F_ASTART = 4;
  localparam int F_START = 5;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  reg_req_t regReq = '0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_CH-1:0] chIrqFlags = '0;
  logic [NUM_CH-1:0] chIrqEnable = '0;
  chan_evt_t chEvt = '0;
  active_evt_t actEvt = '0;
  logic [NUM_LVL-1:0] lvlActive = '0;
  wb_req_t wbReq;
  logic [31:0] d;
  int miscompares = 0;
  int testsRun = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  dma_channel_status_view i_dut (
    .sys_clk(sys_clk), .srst(srst), .regReq(regReq), .rdata(rdata),
    .chIrqFlags(chIrqFlags), .chIrqEnable(chIrqEnable), .chEvt(chEvt),
    .actEvt(actEvt), .lvlActive(lvlActive), .wbReq(wbReq)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // data stands only in the cycle after the strobe
  // sampled mid-cycle, then back on a rising edge for the next drive
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    regReq.rd <= 1'b1;
    regReq.addr <= a;
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    @(negedge sys_clk);
    q = rdata;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk($sformatf("reg %h", a), exp, q);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regReq.wr <= 1'b1;
    regReq.addr <= a;
    regReq.wdata <= v;
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
  endtask

  // one-cycle pulse on one event field, selected by its position
  task automatic cevt(input int f, input logic [NUM_CH-1:0] v);
    @(posedge sys_clk);
    chEvt <= chan_evt_t'({60'h0, v} << (NUM_CH * f));
    @(posedge sys_clk);
    chEvt <= '0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // hang guard, well above the roughly 150 cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    idle(12);
    srst <= 1'b0;
    rchk(OFS_IRQ_SUMMARY, RST_WORD);
    rchk(OFS_BUSY_FLAGS, RST_WORD);
    rchk(OFS_PEND_FLAGS, RST_WORD);
    rchk(OFS_ACTIVE, RST_WORD);
    rchk(8'h00, RST_WORD);
    wr(OFS_BUSY_FLAGS, 32'h0000_0FFF);
    rchk(OFS_BUSY_FLAGS, RST_WORD);
    chIrqFlags <= 12'hFFF;
    chIrqEnable <= 12'hA5A;
    idle(3);
    rchk(OFS_IRQ_SUMMARY, 32'h0000_0A5A);
    @(negedge sys_clk);
    chk("rdata after read", 32'h0, rdata);
    @(posedge sys_clk);
    chIrqEnable <= 12'h000;
    idle(3);
    rchk(OFS_IRQ_SUMMARY, 32'h0);
    chIrqEnable <= 12'hFFF;
    chIrqFlags <= 12'h030;
    idle(3);
    rchk(OFS_IRQ_SUMMARY, 32'h0000_0030);
    chIrqFlags <= 12'h000;
    idle(3);
    rchk(OFS_IRQ_SUMMARY, 32'h0);
    cevt(F_START, 12'h831);
    rchk(OFS_BUSY_FLAGS, 32'h0000_0831);
    cevt(F_DONE, 12'h001);
    rchk(OFS_BUSY_FLAGS, 32'h0000_0830);
    cevt(F_ERR, 12'h800);
    rchk(OFS_BUSY_FLAGS, 32'h0000_0030);
    cevt(F_DIS, 12'h010);
    rchk(OFS_BUSY_FLAGS, 32'h0000_0020);
    cevt(F_REQ, 12'hF0F);
    rchk(OFS_PEND_FLAGS, 32'h0000_0F0F);
    cevt(F_ASTART, 12'h001);
    rchk(OFS_PEND_FLAGS, 32'h0000_0F0E);
    cevt(F_ERR, 12'h002);
    rchk(OFS_PEND_FLAGS, 32'h0000_0F0C);
    cevt(F_DIS, 12'hF04);
    rchk(OFS_PEND_FLAGS, 32'h0000_0008);
    rchk(OFS_BUSY_FLAGS, 32'h0000_0020);
    lvlActive <= 4'hA;
    actEvt.fetchCount <= 1'b1;
    actEvt.fetchedCount <= 16'h1234;
    @(posedge sys_clk);
    actEvt.fetchCount <= 1'b0;
    rchk(OFS_ACTIVE, 32'h1234_800A);
    actEvt.countUpdate <= 1'b1;
    actEvt.newCount <= 16'h00FF;
    @(posedge sys_clk);
    actEvt.countUpdate <= 1'b0;
    rchk(OFS_ACTIVE, 32'h00FF_800A);
    actEvt.grant <= 1'b1;
    actEvt.grantId <= 5'h7;
    @(posedge sys_clk);
    actEvt.grant <= 1'b0;
    @(negedge sys_clk);
    chk("wb valid", 32'h1, 32'(wbReq.valid));
    chk("wb count", 32'h00FF, 32'(wbReq.count));
    chk("wb id", 32'h0, 32'(wbReq.id));
    @(negedge sys_clk);
    chk("wb valid low", 32'h0, 32'(wbReq.valid));
    rd(OFS_ACTIVE, d);
    chk("active id busy", 32'h87, (d >> 8) & 32'hFF);
    actEvt.wbDone <= 1'b1;
    @(posedge sys_clk);
    actEvt.wbDone <= 1'b0;
    rd(OFS_ACTIVE, d);
    chk("active id idle", 32'h07, (d >> 8) & 32'hFF);
    // a grant with no channel active moves the index but writes nothing
    actEvt.grant <= 1'b1;
    actEvt.grantId <= 5'h3;
    @(posedge sys_clk);
    actEvt.grant <= 1'b0;
    @(negedge sys_clk);
    chk("wb refused", 32'h0, 32'(wbReq.valid));
    @(posedge sys_clk);
    for (int i = 0; i < NUM_LVL; i++) begin
      lvlActive <= 4'(1 << i);
      idle(2);
      rd(OFS_ACTIVE, d);
      chk("levels", 32'(1 << i), d & 32'hF);
    end
    actEvt.fetchCount <= 1'b1;
    actEvt.fetchedCount <= 16'hFFFF;
    @(posedge sys_clk);
    actEvt.fetchCount <= 1'b0;
    rchk(OFS_ACTIVE, 32'hFFFF_8308);
    // a second reset mid-run must clear every flag and the snapshot
    srst <= 1'b1;
    lvlActive <= '0;
    idle(2);
    srst <= 1'b0;
    rchk(OFS_BUSY_FLAGS, RST_WORD);
    rchk(OFS_PEND_FLAGS, RST_WORD);
    rchk(OFS_ACTIVE, RST_WORD);
    end_of_test();
  end
endmodule
